/* File: pkg/rzl_map.svh */
// constants of the zone lock controller: opcodes, codes, offsets, timing
`ifndef RZL_MAP_SVH
`define RZL_MAP_SVH
// device address byte opcodes (upper nibble)
`define RZL_OPC_LOCK 4'h7
`define RZL_OPC_FRZ 4'h1
`define RZL_OPC_ARR 4'ha
// data codes
`define RZL_LOCK_ON 8'hff
`define RZL_LOCK_OFF 8'h00
`define RZL_LOCK_DAT 8'hff
`define RZL_FRZ_ADR 8'h55
`define RZL_FRZ_DAT 8'haa
`define RZL_ERASED 8'hff
// array
`define RZL_ARR_BYTES 128
`define RZL_SLAVE_ADR 3'h0
// host register offsets and fields
`define RZL_HR_CMD 3'h0
`define RZL_HR_ARG 3'h1
`define RZL_HR_DAT 3'h2
`define RZL_HR_STAT 3'h3
`define RZL_HR_RES 3'h4
`define RZL_CMD_DSCHG 7
`define RZL_STAT_BUSY 0
`define RZL_STAT_NACK 1
// timing
`define RZL_CLK_MHZ 25
`define RZL_WR_TIME_US 1000
`define RZL_WR_CYCLES (`RZL_WR_TIME_US * `RZL_CLK_MHZ)
`endif

/* File: pkg/rzl_pkg.sv */
// types and decode shared by both ends of the zone lock link
package rzl_pkg;
   typedef enum logic [1:0] {RZL_QRY, RZL_LCK, RZL_FRZ, RZL_ARW} rzl_op_t;
   typedef enum logic [3:0] {D_IDLE, D_DEV, D_RSDEV, D_LKADR, D_LKDAT, D_LKRD, D_LKSTP,
      D_FZADR, D_FZDAT, D_FZSTP, D_WADR, D_WDAT, D_WSTP} rzl_dst_t;
   typedef enum logic [1:0] {P_LOCK, P_FRZ, P_ARR} rzl_pk_t;
   typedef enum logic [2:0] {H_IDLE, H_START, H_SEND, H_ACK, H_RD, H_RDW, H_STOP, H_WAIT} rzl_hst_t;

   // one-hot zone select from a lock register address, zero if invalid
   function automatic logic [3:0] rzl_zone_sel(logic [7:0] b);
      logic [3:0] s;
      s = 4'h0;
      if (b[3:0] == 4'h1 || b[3:0] == 4'h2 || b[3:0] == 4'h4 || b[3:0] == 4'h8) begin
         s = b[3:0];
      end
      return s;
   endfunction : rzl_zone_sel
endpackage : rzl_pkg

/* File: pkg/rzl_link_if.sv */
// byte-level single-wire link between bus master and eeprom
interface rzl_link_if;
   logic m_start;
   logic m_stop;
   logic m_wr_vld;
   logic [7:0] m_wr_byte;
   logic m_rd_req;
   logic m_line_low;
   logic s_ack_vld;
   logic s_nack;
   logic s_rd_vld;
   logic [7:0] s_rd_byte;
   modport host (output m_start, m_stop, m_wr_vld, m_wr_byte, m_rd_req, m_line_low,
      input s_ack_vld, s_nack, s_rd_vld, s_rd_byte);
   modport dev (input m_start, m_stop, m_wr_vld, m_wr_byte, m_rd_req, m_line_low,
      output s_ack_vld, s_nack, s_rd_vld, s_rd_byte);
endinterface : rzl_link_if

/* File: src/rzl_wr_timer.sv */
// self-timed write cycle counter
`include "rzl_map.svh"
module rzl_wr_timer #(
   parameter int unsigned CYCLES = `RZL_WR_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q;

   // busy stands exactly CYCLES cycles, done pulses in the next one
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            cnt_q <= W'(CYCLES - 1);
         end else if (busy) begin
            if (cnt_q == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end
endmodule : rzl_wr_timer

/* File: src/rzl_dev.sv */
// eeprom end: zone lock query, lock write, freeze and array write gating
// How it works
// - lock query starts with 7h write byte, acked
// - lock address: upper nibble ignored, must be valid
// - repeated start read returns 00h or FFh
// - lock write: 7h byte, address, FFh, all acked
// - stop after data starts cycle, sets lock
// - stop elsewhere aborts lock write, no change
// - commands ignored while write cycle runs
// - lock bits only go zero to one
// - freeze opcode 1h: ack unless already frozen
// - freeze needs 55h then AAh, both acked
// - wrong freeze bytes get nack, no freeze
// - freeze completes only on stop after AAh
// - once frozen, lock bits never change again
// - master keeps line released during write cycle
// - stop is an empty frame, line high
// - array write address bytes always acked
// - data to locked zone: nack, no programming
// - data to open zone: ack, normal write
// - array reads FFh as shipped
// - four 32-byte zones, lock addresses 01,02,04,08
// - lock bits survive resets, zero is writable; power-on reset rst_b clears them here
//
// Our own choices: the plain strobed port and the address map.
`include "rzl_map.svh"
module rzl_dev #(
   parameter int unsigned WR_CYCLES = `RZL_WR_CYCLES,
   parameter logic [2:0] SLAVE_ADR = `RZL_SLAVE_ADR
) (
   // clock and power-on reset
   input wire logic clk,
   input wire logic rst_b,
   // single-wire link, byte level
   rzl_link_if.dev lnk,
   // device reset that keeps nonvolatile state
   input wire logic proto_clr,
   // observation
   input wire logic [6:0] peek_addr,
   output logic [7:0] peek_data,
   output logic [3:0] zone_lock,
   output logic frozen,
   output logic busy
);
   rzl_pkg::rzl_dst_t st_q;
   rzl_pkg::rzl_dst_t st_d;
   rzl_pkg::rzl_pk_t pk_q;
   logic [3:0] sel_q;
   logic [6:0] wadr_q;
   logic [7:0] wdat_q;
   logic [7:0] mem_q [`RZL_ARR_BYTES];
   logic corrupt_q;
   logic ans_d;
   logic nack_d;
   logic quiet;
   logic prog_go;
   logic wr_done;
   logic [3:0] opc;
   logic rw;

   assign opc = lnk.m_wr_byte[7:4];
   assign rw = lnk.m_wr_byte[0];
   // a busy device or a line discharge drops everything on the link
   assign quiet = busy || proto_clr || lnk.m_line_low;
   assign prog_go = lnk.m_stop && !quiet && (st_q == rzl_pkg::D_LKSTP || st_q == rzl_pkg::D_FZSTP ||
      st_q == rzl_pkg::D_WSTP);

   // byte decode and answer
   always_comb begin
      st_d = st_q;
      ans_d = 1'b0;
      nack_d = 1'b0;
      if (quiet) begin
         st_d = rzl_pkg::D_IDLE;
      end else if (lnk.m_stop) begin
         st_d = rzl_pkg::D_IDLE;
      end else if (lnk.m_start) begin
         st_d = (st_q == rzl_pkg::D_LKDAT) ? rzl_pkg::D_RSDEV : rzl_pkg::D_DEV;
      end else if (lnk.m_wr_vld) begin
         ans_d = 1'b1;
         nack_d = 1'b1;
         st_d = rzl_pkg::D_IDLE;
         unique case (st_q)
            rzl_pkg::D_DEV, rzl_pkg::D_RSDEV: begin
               if (lnk.m_wr_byte[3:1] != SLAVE_ADR) begin
                  ans_d = 1'b0;
               end else if (st_q == rzl_pkg::D_RSDEV) begin
                  if (opc == `RZL_OPC_LOCK && rw) begin
                     nack_d = 1'b0;
                     st_d = rzl_pkg::D_LKRD;
                  end
               end else if (!rw && opc == `RZL_OPC_LOCK) begin
                  nack_d = 1'b0;
                  st_d = rzl_pkg::D_LKADR;
               end else if (!rw && opc == `RZL_OPC_FRZ && !frozen) begin
                  nack_d = 1'b0;
                  st_d = rzl_pkg::D_FZADR;
               end else if (!rw && opc == `RZL_OPC_ARR) begin
                  nack_d = 1'b0;
                  st_d = rzl_pkg::D_WADR;
               end
            end
            rzl_pkg::D_LKADR: begin
               if (rzl_pkg::rzl_zone_sel(lnk.m_wr_byte) != 4'h0) begin
                  nack_d = 1'b0;
                  st_d = rzl_pkg::D_LKDAT;
               end
            end
            rzl_pkg::D_LKDAT: begin
               if (lnk.m_wr_byte == `RZL_LOCK_DAT && !frozen) begin
                  nack_d = 1'b0;
                  st_d = rzl_pkg::D_LKSTP;
               end
            end
            rzl_pkg::D_FZADR: begin
               if (lnk.m_wr_byte == `RZL_FRZ_ADR) begin
                  nack_d = 1'b0;
                  st_d = rzl_pkg::D_FZDAT;
               end
            end
            rzl_pkg::D_FZDAT: begin
               if (lnk.m_wr_byte == `RZL_FRZ_DAT) begin
                  nack_d = 1'b0;
                  st_d = rzl_pkg::D_FZSTP;
               end
            end
            rzl_pkg::D_WADR: begin
               nack_d = 1'b0;
               st_d = rzl_pkg::D_WDAT;
            end
            rzl_pkg::D_WDAT: begin
               if (!zone_lock[wadr_q[6:5]]) begin
                  nack_d = 1'b0;
                  st_d = rzl_pkg::D_WSTP;
               end
            end
            rzl_pkg::D_IDLE, rzl_pkg::D_LKRD, rzl_pkg::D_LKSTP, rzl_pkg::D_FZSTP, rzl_pkg::D_WSTP: begin
               ans_d = 1'b0;
            end
            default: begin
               ans_d = 1'b0;
            end
         endcase
      end
   end

   // protocol state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= rzl_pkg::D_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // operands caught from the bytes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_q <= 4'h0;
         wadr_q <= 7'h00;
         wdat_q <= 8'h00;
      end else if (lnk.m_wr_vld && !quiet) begin
         if (st_q == rzl_pkg::D_LKADR) begin
            sel_q <= rzl_pkg::rzl_zone_sel(lnk.m_wr_byte);
         end
         if (st_q == rzl_pkg::D_WADR) begin
            wadr_q <= lnk.m_wr_byte[6:0];
         end
         if (st_q == rzl_pkg::D_WDAT) begin
            wdat_q <= lnk.m_wr_byte;
         end
      end
   end

   // answers to the master
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lnk.s_ack_vld <= 1'b0;
         lnk.s_nack <= 1'b0;
         lnk.s_rd_vld <= 1'b0;
         lnk.s_rd_byte <= 8'h00;
      end else begin
         lnk.s_ack_vld <= ans_d;
         lnk.s_nack <= nack_d;
         lnk.s_rd_vld <= 1'b0;
         if (lnk.m_rd_req && !quiet && st_q == rzl_pkg::D_LKRD) begin
            lnk.s_rd_vld <= 1'b1;
            lnk.s_rd_byte <= ((zone_lock & sel_q) != 4'h0) ? `RZL_LOCK_ON : `RZL_LOCK_OFF;
         end
      end
   end

   // self-timed programming cycle
   rzl_wr_timer #(
      .CYCLES(WR_CYCLES)
   ) u_tmr (
      .clk(clk),
      .rst_b(rst_b),
      .start(prog_go),
      .busy(busy),
      .done(wr_done)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pk_q <= rzl_pkg::P_LOCK;
      end else if (prog_go) begin
         unique case (st_q)
            rzl_pkg::D_FZSTP: pk_q <= rzl_pkg::P_FRZ;
            rzl_pkg::D_WSTP: pk_q <= rzl_pkg::P_ARR;
            default: pk_q <= rzl_pkg::P_LOCK;
         endcase
      end
   end

   // pulling the line low during the cycle spoils the result
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         corrupt_q <= 1'b0;
      end else if (prog_go) begin
         corrupt_q <= 1'b0;
      end else if (busy && lnk.m_line_low) begin
         corrupt_q <= 1'b1;
      end
   end

   // nonvolatile state: cleared only by power-on reset, never by proto_clr
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         zone_lock <= 4'h0;
         frozen <= 1'b0;
      end else if (wr_done && !corrupt_q) begin
         if (pk_q == rzl_pkg::P_LOCK && !frozen) begin
            zone_lock <= zone_lock | sel_q;
         end
         if (pk_q == rzl_pkg::P_FRZ) begin
            frozen <= 1'b1;
         end
      end
   end

   for (genvar i = 0; i < `RZL_ARR_BYTES; i++) begin : g_mem
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            mem_q[i] <= `RZL_ERASED;
         end else if (wr_done && !corrupt_q && pk_q == rzl_pkg::P_ARR && wadr_q == 7'(i)) begin
            mem_q[i] <= wdat_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         peek_data <= `RZL_ERASED;
      end else begin
         peek_data <= mem_q[peek_addr];
      end
   end
endmodule : rzl_dev

/* File: src/rzl_host.sv */
// bus master end: runs zone lock, freeze and array write sequences
`include "rzl_map.svh"
module rzl_host #(
   parameter int unsigned WR_CYCLES = `RZL_WR_CYCLES,
   parameter logic [2:0] SLAVE_ADR = `RZL_SLAVE_ADR
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // single-wire link, byte level
   rzl_link_if.host lnk,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   rzl_pkg::rzl_hst_t st_q;
   rzl_pkg::rzl_op_t op_q;
   logic [1:0] k_q;
   logic [7:0] arg_q;
   logic [7:0] dat_q;
   logic [7:0] res_q;
   logic nack_q;
   logic t_busy;
   logic t_done;

   // k-th byte of a sequence
   function automatic logic [7:0] seq_byte(rzl_pkg::rzl_op_t op, logic [1:0] k);
      logic [3:0] opc;
      logic [7:0] b;
      opc = (op == rzl_pkg::RZL_FRZ) ? `RZL_OPC_FRZ : (op == rzl_pkg::RZL_ARW) ? `RZL_OPC_ARR : `RZL_OPC_LOCK;
      if (k == 2'd0) begin
         b = {opc, SLAVE_ADR, 1'b0};
      end else if (k == 2'd1) begin
         b = (op == rzl_pkg::RZL_FRZ) ? `RZL_FRZ_ADR : arg_q;
      end else begin
         unique case (op)
            rzl_pkg::RZL_QRY: b = {opc, SLAVE_ADR, 1'b1};
            rzl_pkg::RZL_LCK: b = `RZL_LOCK_DAT;
            rzl_pkg::RZL_FRZ: b = `RZL_FRZ_DAT;
            rzl_pkg::RZL_ARW: b = dat_q;
         endcase
      end
      return b;
   endfunction : seq_byte

   // waits out the cycle with the line left released
   rzl_wr_timer #(
      .CYCLES(WR_CYCLES)
   ) u_tmr (
      .clk(clk),
      .rst_b(rst_b),
      .start(lnk.m_stop && st_q == rzl_pkg::H_WAIT),
      .busy(t_busy),
      .done(t_done)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         arg_q <= 8'h00;
         dat_q <= 8'h00;
      end else if (reg_wr && reg_addr == `RZL_HR_ARG) begin
         arg_q <= reg_wdata;
      end else if (reg_wr && reg_addr == `RZL_HR_DAT) begin
         dat_q <= reg_wdata;
      end
   end

   // sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= rzl_pkg::H_IDLE;
         op_q <= rzl_pkg::RZL_QRY;
         k_q <= 2'd0;
         nack_q <= 1'b0;
         res_q <= 8'h00;
         lnk.m_start <= 1'b0;
         lnk.m_stop <= 1'b0;
         lnk.m_wr_vld <= 1'b0;
         lnk.m_wr_byte <= 8'h00;
         lnk.m_rd_req <= 1'b0;
         lnk.m_line_low <= 1'b0;
      end else begin
         lnk.m_start <= 1'b0;
         lnk.m_stop <= 1'b0;
         lnk.m_wr_vld <= 1'b0;
         lnk.m_rd_req <= 1'b0;
         lnk.m_line_low <= 1'b0;
         unique case (st_q)
            rzl_pkg::H_IDLE: begin
               if (reg_wr && reg_addr == `RZL_HR_CMD) begin
                  if (reg_wdata[`RZL_CMD_DSCHG]) begin
                     lnk.m_line_low <= 1'b1; // only from idle
                  end else begin
                     op_q <= rzl_pkg::rzl_op_t'(reg_wdata[1:0]);
                     k_q <= 2'd0;
                     nack_q <= 1'b0;
                     st_q <= rzl_pkg::H_START;
                  end
               end
            end
            rzl_pkg::H_START: begin
               lnk.m_start <= 1'b1;
               st_q <= rzl_pkg::H_SEND;
            end
            rzl_pkg::H_SEND: begin
               lnk.m_wr_vld <= 1'b1;
               lnk.m_wr_byte <= seq_byte(op_q, k_q);
               st_q <= rzl_pkg::H_ACK;
            end
            rzl_pkg::H_ACK: begin
               if (lnk.s_ack_vld) begin
                  if (lnk.s_nack) begin
                     nack_q <= 1'b1;
                     st_q <= rzl_pkg::H_STOP;
                  end else if (k_q == 2'd2) begin
                     st_q <= (op_q == rzl_pkg::RZL_QRY) ? rzl_pkg::H_RD : rzl_pkg::H_STOP;
                  end else begin
                     k_q <= k_q + 2'd1;
                     st_q <= (op_q == rzl_pkg::RZL_QRY && k_q == 2'd1) ? rzl_pkg::H_START : rzl_pkg::H_SEND;
                  end
               end
            end
            rzl_pkg::H_RD: begin
               lnk.m_rd_req <= 1'b1;
               st_q <= rzl_pkg::H_RDW;
            end
            rzl_pkg::H_RDW: begin
               if (lnk.s_rd_vld) begin
                  res_q <= lnk.s_rd_byte;
                  st_q <= rzl_pkg::H_STOP;
               end
            end
            rzl_pkg::H_STOP: begin
               lnk.m_stop <= 1'b1;
               st_q <= (op_q != rzl_pkg::RZL_QRY && !nack_q) ? rzl_pkg::H_WAIT : rzl_pkg::H_IDLE;
            end
            rzl_pkg::H_WAIT: begin
               if (t_done) begin
                  st_q <= rzl_pkg::H_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `RZL_HR_ARG: reg_rdata <= arg_q;
            `RZL_HR_DAT: reg_rdata <= dat_q;
            `RZL_HR_STAT: reg_rdata <= {6'h00, nack_q, st_q != rzl_pkg::H_IDLE};
            `RZL_HR_RES: reg_rdata <= res_q;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : rzl_host

/* File: testbench/rzl_checker.sv */
// assertions on the byte-level zone lock link
module rzl_checker #(
   parameter int unsigned WR_CYCLES = 25000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // master side
   input wire logic m_start,
   input wire logic m_stop,
   input wire logic m_wr_vld,
   input wire logic [7:0] m_wr_byte,
   input wire logic m_rd_req,
   input wire logic m_line_low,
   // device side
   input wire logic s_ack_vld,
   input wire logic s_nack,
   input wire logic s_rd_vld,
   input wire logic [7:0] s_rd_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic [1:0] cnt_q;
   logic [7:0] opc_q;
   logic [7:0] adr_q;
   logic arm_q;
   logic frz_q;
   logic [3:0] lck_q;
   logic [15:0] wait_q;
   logic go;
   logic [3:0] op;
   assign go = m_stop && arm_q;
   assign op = opc_q[7:4];
   // byte position and first two bytes of the frame
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 2'h0;
         opc_q <= 8'h00;
         adr_q <= 8'h00;
      end else if (m_start) begin
         cnt_q <= 2'h0;
      end else if (m_wr_vld) begin
         cnt_q <= cnt_q + 2'h1;
         if (cnt_q == 2'h0) begin
            opc_q <= m_wr_byte;
         end
         if (cnt_q == 2'h1) begin
            adr_q <= m_wr_byte;
         end
      end
   end
   // a stop right after an acked third byte launches a write cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_q <= 1'b0;
      end else if (m_start || m_stop) begin
         arm_q <= 1'b0;
      end else if (s_ack_vld) begin
         arm_q <= !s_nack && cnt_q == 2'h3;
      end
   end
   // shadow of lock bits, freeze and the write cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= 16'h0000;
         lck_q <= 4'h0;
         frz_q <= 1'b0;
      end else if (go) begin
         wait_q <= 16'(WR_CYCLES);
         lck_q <= lck_q | (op == 4'h7 ? adr_q[3:0] : 4'h0);
         frz_q <= frz_q || op == 4'h1;
      end else if (wait_q != 16'h0000) begin
         wait_q <= wait_q - 16'h0001;
      end
   end
   property p_answer_cause;
      s_ack_vld |-> $past(m_wr_vld);
   endproperty
   a_answer_cause: assert property (p_answer_cause) else $error("answer without a byte");
   property p_one_pulse;
      $onehot0({m_start, m_stop, m_wr_vld, m_rd_req, m_line_low});
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("two master pulses at once");
   property p_lock_ack;
      m_start ##1 (m_wr_vld && m_wr_byte[7:4] == 4'h7 && !m_wr_byte[0] && wait_q == 16'h0000)
         |=> s_ack_vld && !s_nack;
   endproperty
   a_lock_ack: assert property (p_lock_ack) else $error("lock opcode not acked");
   property p_zone_addr;
      s_ack_vld && op == 4'h7 && cnt_q == 2'h2 |-> s_nack == !$onehot(adr_q[3:0]);
   endproperty
   a_zone_addr: assert property (p_zone_addr) else $error("lock address answer wrong");
   property p_query_val;
      s_rd_vld |-> s_rd_byte == ((lck_q & adr_q[3:0]) != 4'h0 ? 8'hff : 8'h00);
   endproperty
   a_query_val: assert property (p_query_val) else $error("lock status byte wrong");
   property p_lock_frozen;
      s_ack_vld && op == 4'h7 && cnt_q == 2'h3 && frz_q |-> s_nack;
   endproperty
   a_lock_frozen: assert property (p_lock_frozen) else $error("lock accepted after freeze");
   property p_frz_first;
      s_ack_vld && op == 4'h1 && cnt_q == 2'h1 |-> s_nack == frz_q;
   endproperty
   a_frz_first: assert property (p_frz_first) else $error("freeze opcode answer wrong");
   property p_arr_addr;
      s_ack_vld && op == 4'ha && cnt_q == 2'h2 |-> !s_nack;
   endproperty
   a_arr_addr: assert property (p_arr_addr) else $error("array address refused");
   property p_arr_data;
      s_ack_vld && op == 4'ha && cnt_q == 2'h3 |-> s_nack == lck_q[adr_q[6:5]];
   endproperty
   a_arr_data: assert property (p_arr_data) else $error("array data answer wrong");
   property p_quiet;
      wait_q != 16'h0000 |-> !s_ack_vld && !s_rd_vld;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer during write cycle");
   property p_line_free;
      wait_q != 16'h0000 |-> !m_line_low;
   endproperty
   a_line_free: assert property (p_line_free) else $error("line pulled low during write cycle");
   c_lock: cover property (go && op == 4'h7);
   c_frz: cover property (go && op == 4'h1);
   c_arr_nack: cover property (s_ack_vld && s_nack && op == 4'ha);
endmodule : rzl_checker

/* File: testbench/tb.sv */
// self-checking bench for the zone lock host and device pair
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WR = 20;
   logic clk;
   logic rst_b;
   logic reg_wr;
   logic reg_rd;
   logic pclr;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] peek_data;
   logic [7:0] v;
   logic [6:0] peek_addr;
   logic [3:0] zone_lock;
   logic [3:0] zone2;
   logic frozen;
   logic frozen2;
   logic busy2;
   int error_cnt = 0;
   int comparisons = 0;
   rzl_link_if lnk();
   rzl_link_if lnk2();
   rzl_host #(.WR_CYCLES(WR)) rzl_host_inst (.clk(clk), .rst_b(rst_b), .lnk(lnk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   rzl_dev #(.WR_CYCLES(WR)) rzl_dev_inst (.clk(clk), .rst_b(rst_b), .lnk(lnk), .proto_clr(pclr),
      .peek_addr(peek_addr), .peek_data(peek_data), .zone_lock(zone_lock), .frozen(frozen), .busy());
   // second device, driven directly to break the master's side of the protocol
   rzl_dev #(.WR_CYCLES(WR)) rzl_dev_inst2 (.clk(clk), .rst_b(rst_b), .lnk(lnk2), .proto_clr(1'b0),
      .peek_addr(7'h00), .peek_data(), .zone_lock(zone2), .frozen(frozen2), .busy(busy2));
   rzl_checker #(.WR_CYCLES(WR)) rzl_checker_inst (.clk(clk), .rst_b(rst_b), .m_start(lnk.m_start),
      .m_stop(lnk.m_stop), .m_wr_vld(lnk.m_wr_vld), .m_wr_byte(lnk.m_wr_byte), .m_rd_req(lnk.m_rd_req),
      .m_line_low(lnk.m_line_low), .s_ack_vld(lnk.s_ack_vld), .s_nack(lnk.s_nack),
      .s_rd_vld(lnk.s_rd_vld), .s_rd_byte(lnk.s_rd_byte));
   task automatic final_report;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // one host sequence, waits for idle and compares the nack flag
   task automatic run(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, input logic n);
      int k;
      wr(3'h1, a);
      wr(3'h2, d);
      wr(3'h0, c);
      repeat (3) @(posedge clk);
      k = 0;
      rd(3'h3);
      while (v[0] !== 1'b0 && k < 200) begin
         rd(3'h3);
         k++;
      end
      chk({7'h0, v[0]}, 8'h00);
      chk({7'h0, v[1]}, {7'h0, n});
   endtask : run
   task automatic q(input logic [7:0] a, input logic [7:0] exp);
      run(8'h00, a, 8'h00, 1'b0);
      rd(3'h4);
      chk(v, exp);
   endtask : q
   task automatic pk(input logic [6:0] a, input logic [7:0] exp);
      @(posedge clk);
      peek_addr <= a;
      @(posedge clk);
      #1 chk(peek_data, exp);
   endtask : pk
   // start (k=0), stop (k=1) or line low (k=2) on the second link
   task automatic ev(input int k);
      @(posedge clk);
      lnk2.m_start <= (k == 0);
      lnk2.m_stop <= (k == 1);
      lnk2.m_line_low <= (k == 2);
      @(posedge clk);
      lnk2.m_start <= 1'b0;
      lnk2.m_stop <= 1'b0;
      lnk2.m_line_low <= 1'b0;
   endtask : ev
   // exp: 02 ack, 03 nack, 00 silence
   task automatic b2(input logic [7:0] b, input logic [7:0] exp);
      @(posedge clk);
      lnk2.m_wr_vld <= 1'b1;
      lnk2.m_wr_byte <= b;
      @(posedge clk);
      lnk2.m_wr_vld <= 1'b0;
      #1 chk({6'h0, lnk2.s_ack_vld, lnk2.s_ack_vld & lnk2.s_nack}, exp);
   endtask : b2
   task automatic t_reset;
      chk({4'h0, zone_lock}, 8'h00);
      chk({7'h0, frozen}, 8'h00);
      pk(7'h00, 8'hff);
      pk(7'h7f, 8'hff);
      rd(3'h6);
      chk(v, 8'h00);
   endtask : t_reset
   task automatic t_query;
      logic [7:0] c [4] = '{8'h01, 8'hf2, 8'h04, 8'h08};
      for (int i = 0; i < 4; i++) begin
         q(c[i], 8'h00);
      end
   endtask : t_query
   task automatic t_lock;
      run(8'h01, 8'h02, 8'h00, 1'b0);
      chk({4'h0, zone_lock}, 8'h02);
      q(8'h02, 8'hff);
      q(8'h01, 8'h00);
      run(8'h01, 8'h03, 8'h00, 1'b1);
      chk({4'h0, zone_lock}, 8'h02);
   endtask : t_lock
   task automatic t_array;
      run(8'h03, 8'h25, 8'h5a, 1'b1);
      pk(7'h25, 8'hff);
      run(8'h03, 8'h45, 8'h5a, 1'b0);
      pk(7'h45, 8'h5a);
      rd(3'h2);
      chk(v, 8'h5a);
   endtask : t_array
   task automatic t_clr;
      @(posedge clk);
      pclr <= 1'b1;
      @(posedge clk);
      pclr <= 1'b0;
      wr(3'h0, 8'h80);
      q(8'h02, 8'hff);
   endtask : t_clr
   task automatic t_freeze;
      run(8'h02, 8'h00, 8'h00, 1'b0);
      chk({7'h0, frozen}, 8'h01);
      run(8'h02, 8'h00, 8'h00, 1'b1);
      run(8'h01, 8'h01, 8'h00, 1'b1);
      chk({4'h0, zone_lock}, 8'h02);
   endtask : t_freeze
   task automatic t_faults;
      ev(0);
      b2(8'h10, 8'h02);
      b2(8'h56, 8'h03);
      ev(1);
      repeat (WR + 4) @(posedge clk);
      chk({7'h0, frozen2}, 8'h00);
      ev(0);
      b2(8'h70, 8'h02);
      b2(8'h01, 8'h02);
      b2(8'h7e, 8'h03);
      ev(1);
      ev(0);
      b2(8'h70, 8'h02);
      b2(8'h01, 8'h02);
      ev(1);
      repeat (WR + 4) @(posedge clk);
      chk({4'h0, zone2}, 8'h00);
      ev(0);
      b2(8'h70, 8'h02);
      b2(8'h01, 8'h02);
      b2(8'hff, 8'h02);
      ev(1);
      #1 chk({7'h0, busy2}, 8'h01);
      ev(0);
      b2(8'h70, 8'h00);
      ev(1);
      repeat (WR + 4) @(posedge clk);
      chk({4'h0, zone2}, 8'h01);
      chk({7'h0, busy2}, 8'h00);
      ev(0);
      b2(8'h70, 8'h02);
      b2(8'h02, 8'h02);
      b2(8'hff, 8'h02);
      ev(1);
      ev(2);
      repeat (WR + 4) @(posedge clk);
      chk({4'h0, zone2}, 8'h01);
   endtask : t_faults
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      pclr = 1'b0;
      peek_addr = 7'h00;
      lnk2.m_start = 1'b0;
      lnk2.m_stop = 1'b0;
      lnk2.m_wr_vld = 1'b0;
      lnk2.m_wr_byte = 8'h00;
      lnk2.m_rd_req = 1'b0;
      lnk2.m_line_low = 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_query;
      t_lock;
      t_array;
      t_clr;
      t_freeze;
      t_faults;
      final_report;
   end
   initial begin
      #400000;
      error_cnt++;
      final_report;
   end
endmodule : tb
